/* File: include/mcx_defines.svh */
// Constants for the instruction execute block
`ifndef MCX_DEFINES_SVH
`define MCX_DEFINES_SVH

`define MCX_CLK_PERIOD_NS   100
`define MCX_PHASES          4
`define MCX_PC_W            13
`define MCX_INSTR_W         14
`define MCX_STACK_DEPTH     8

// Opcode patterns (instruction bits 13:11, 13:10, 13:8 or 13:7; clear watchdog uses all 14 bits)
`define MCX_OP_CALL         3'h4
`define MCX_OP_GOTO         3'h5
`define MCX_OP_CLRREG       7'h03
`define MCX_OP_CLRACC       7'h02
`define MCX_OP_CLEAR_WATCHDOG_OP       14'h0064
`define MCX_OP_INVERT_REGISTER_OP         6'h09
`define MCX_OP_DECREMENT_REGISTER_OP         6'h03
`define MCX_OP_DECREMENT_SKIP_ZERO_OP       6'h0b
`define MCX_OP_INCREMENT_REGISTER_OP         6'h0a
`define MCX_OP_INCREMENT_SKIP_ZERO_OP       6'h0f
`define MCX_OP_OR_LITERAL_OP        6'h38
`define MCX_OP_BIT_TEST_SKIP_SET_OP        4'h7

`define MCX_RESET_VECTOR    13'h0000
`define MCX_ACC_RESET       8'h00

`endif

/* File: include/mcx_pkg.sv */
// Types shared by the instruction execute block
package mcx_pkg;
   typedef enum logic [3:0] {
      MCX_Q1 = 4'h1,
      MCX_Q2 = 4'h2,
      MCX_Q3 = 4'h4,
      MCX_Q4 = 4'h8
   } mcx_phase_e;

   typedef enum logic [3:0] {
      MCX_K_NOP   = 4'h0,
      MCX_K_CALL  = 4'h1,
      MCX_K_GOTO  = 4'h2,
      MCX_K_CLEAR_REGISTER_OP  = 4'h3,
      MCX_K_CLEAR_ACCUMULATOR_OP  = 4'h4,
      MCX_K_CLRWD = 4'h5,
      MCX_K_INVERT_REGISTER_OP  = 4'h6,
      MCX_K_DEC   = 4'h7,
      MCX_K_DECSZ = 4'h8,
      MCX_K_INC   = 4'h9,
      MCX_K_INCSZ = 4'ha,
      MCX_K_IORL  = 4'hb,
      MCX_K_BTSS  = 4'hc
   } mcx_kind_e;

   typedef logic [12:0] mcx_pc_t;
endpackage

/* File: include/mcx_stack_if.sv */
// Return stack port between the core and its stack memory
`timescale 1ns/1ps
interface mcx_stack_if;
   logic        push;
   logic [12:0] push_data;
   logic [12:0] stack_head;
   modport core  (output push, output push_data, input stack_head);
   modport store (input push, input push_data, output stack_head);
endinterface

/* File: verilog/mcx_stack_mem.sv */
// Circular return stack memory with registered head output
`timescale 1ns/1ps
`include "mcx_defines.svh"
module mcx_stack_mem (
   input  wire logic   clk,
   input  wire logic   rst_n,
   mcx_stack_if.store  stk
);
   import mcx_pkg::*;

   logic [12:0] mem [0:`MCX_STACK_DEPTH-1];
   logic [2:0]  ptr;
   wire  [2:0]  next_ptr = ptr + 3'h1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr            <= 3'h0;
         stk.stack_head <= 13'h0000;
      end else if (stk.push) begin
         ptr            <= next_ptr;
         stk.stack_head <= stk.push_data;
      end
   end

   always_ff @(posedge clk) begin
      if (stk.push) begin
         mem[next_ptr] <= stk.push_data;
      end
   end
endmodule // mcx_stack_mem

/* File: verilog/mcx_wdt_clr.sv */
// Watchdog counter and prescaler count with clear request
`timescale 1ns/1ps
module mcx_wdt_clr (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic       tick,
   input  wire logic [2:0] ratio,
   output logic      [7:0] count,
   output logic      [7:0] pre_count
);
   wire [7:0] pre_lim = 8'h01 << ratio;
   wire       pre_end = (pre_count + 8'h01) >= pre_lim;

   // Clear touches only the running counts, never ratio or assignment
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count     <= 8'h00;
         pre_count <= 8'h00;
      end else if (clear) begin
         count     <= 8'h00;
         pre_count <= 8'h00;
      end else if (tick) begin
         pre_count <= pre_end ? 8'h00 : pre_count + 8'h01;
         count     <= pre_end ? count + 8'h01 : count;
      end
   end
endmodule // mcx_wdt_clr

/* File: verilog/mcx_core.sv */
// Instruction decode and execute for a subset of the core's set
//
// Overview of operation
// - Call pushes next address, loads PC
// - Call takes two cycles, second idle
// - Goto loads PC, no push, two cycles
// - Clear register writes zero, sets zero
// - Clear accumulator, sets zero, low bits ignored
// - Clear watchdog counts, set both status flags
// - Prescaler ratio and assignment stay unchanged
// - Complement register into chosen destination
// - Decrement register into chosen destination
// - Decrement and skip on zero, flags untouched
// - Skip replaces prefetched instruction by idle
// - Increment modulo 256 into chosen destination
// - Increment and skip on wrap, flags untouched
// - OR literal into accumulator, update zero
// - Bit test skips when selected bit set
// - Four phases: decode, read, process, write
`timescale 1ns/1ps
`include "mcx_defines.svh"
module mcx_core (
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire logic [13:0]   instr_data,
   output logic      [12:0]   pc,
   output logic      [6:0]    file_addr,
   input  wire logic [7:0]    file_rdata,
   output logic      [7:0]    file_wdata,
   output logic               file_we,
   output logic      [7:0]    acc,
   output logic               zero_flag,
   output logic               watchdog_expiry_flag_n,
   output logic               sleep_entry_flag_n,
   input  wire logic [4:0]    pc_upper_holding_latch,
   input  wire logic [2:0]    wdt_ratio,
   input  wire logic          wdt_tick,
   output logic      [7:0]    watchdog_counter,
   output logic      [12:0]   stack_head,
   output logic      [3:0]    phase
);
   import mcx_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // ------------------------------------------------------------
   // Phase sequencer
   // ------------------------------------------------------------
   mcx_phase_e q;
   mcx_phase_e next_q;
   always_comb begin
      case (q)
         MCX_Q1:  next_q = MCX_Q2;
         MCX_Q2:  next_q = MCX_Q3;
         MCX_Q3:  next_q = MCX_Q4;
         MCX_Q4:  next_q = MCX_Q1;
         default: next_q = MCX_Q1;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) q <= MCX_Q1;
      else        q <= next_q;
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [13:0] ir;
   logic        flush;
   logic [7:0]  opnd;
   logic [7:0]  result;
   mcx_kind_e   kind;

   wire       dest_f  = ir[7];
   wire [6:0] f_field = ir[6:0];
   wire [2:0] b_field = ir[9:7];
   wire [7:0] lit8    = ir[7:0];
   wire [10:0] lit11  = ir[10:0];

   always_comb begin
      if (ir[13:11] == `MCX_OP_CALL)             kind = MCX_K_CALL;
      else if (ir[13:11] == `MCX_OP_GOTO)        kind = MCX_K_GOTO;
      else if (ir[13:7] == `MCX_OP_CLRREG)       kind = MCX_K_CLEAR_REGISTER_OP;
      else if (ir[13:7] == `MCX_OP_CLRACC)       kind = MCX_K_CLEAR_ACCUMULATOR_OP;
      else if (ir == `MCX_OP_CLEAR_WATCHDOG_OP)             kind = MCX_K_CLRWD;
      else if (ir[13:8] == `MCX_OP_INVERT_REGISTER_OP)         kind = MCX_K_INVERT_REGISTER_OP;
      else if (ir[13:8] == `MCX_OP_DECREMENT_REGISTER_OP)         kind = MCX_K_DEC;
      else if (ir[13:8] == `MCX_OP_DECREMENT_SKIP_ZERO_OP)       kind = MCX_K_DECSZ;
      else if (ir[13:8] == `MCX_OP_INCREMENT_REGISTER_OP)         kind = MCX_K_INC;
      else if (ir[13:8] == `MCX_OP_INCREMENT_SKIP_ZERO_OP)       kind = MCX_K_INCSZ;
      else if (ir[13:8] == `MCX_OP_OR_LITERAL_OP)        kind = MCX_K_IORL;
      else if (ir[13:10] == `MCX_OP_BIT_TEST_SKIP_SET_OP)       kind = MCX_K_BTSS;
      else                                       kind = MCX_K_NOP;
   end

   // A flushed cycle executes nothing at all
   wire       live      = !flush;
   wire       is_branch = live && (kind == MCX_K_CALL || kind == MCX_K_GOTO);
   wire [12:0] br_tgt   = {pc_upper_holding_latch[4:3], lit11};

   wire [7:0] inc_val = opnd + 8'h01;
   wire [7:0] dec_val = opnd - 8'h01;
   logic [7:0] alu;
   always_comb begin
      case (kind)
         MCX_K_CLEAR_REGISTER_OP:  alu = 8'h00;
         MCX_K_CLEAR_ACCUMULATOR_OP:  alu = 8'h00;
         MCX_K_INVERT_REGISTER_OP:  alu = ~opnd;
         MCX_K_DEC,
         MCX_K_DECSZ: alu = dec_val;
         MCX_K_INC,
         MCX_K_INCSZ: alu = inc_val;
         MCX_K_IORL:  alu = acc | lit8;
         default:     alu = opnd;
      endcase
   end

   wire wr_acc = live && ((kind == MCX_K_CLEAR_ACCUMULATOR_OP) || (kind == MCX_K_IORL) ||
                 (!dest_f && (kind == MCX_K_INVERT_REGISTER_OP || kind == MCX_K_DEC ||
                  kind == MCX_K_DECSZ || kind == MCX_K_INC ||
                  kind == MCX_K_INCSZ)));
   wire wr_reg = live && ((kind == MCX_K_CLEAR_REGISTER_OP) ||
                 (dest_f && (kind == MCX_K_INVERT_REGISTER_OP || kind == MCX_K_DEC ||
                  kind == MCX_K_DECSZ || kind == MCX_K_INC ||
                  kind == MCX_K_INCSZ)));
   wire upd_z  = live && (kind == MCX_K_CLEAR_REGISTER_OP || kind == MCX_K_CLEAR_ACCUMULATOR_OP ||
                 kind == MCX_K_INVERT_REGISTER_OP || kind == MCX_K_DEC ||
                 kind == MCX_K_INC || kind == MCX_K_IORL);
   wire bit_set = opnd[b_field];
   wire do_skip = live && (((kind == MCX_K_DECSZ || kind == MCX_K_INCSZ)
                  && result == 8'h00) ||
                  (kind == MCX_K_BTSS && bit_set));
   wire do_wdt  = live && (kind == MCX_K_CLRWD);

   // ------------------------------------------------------------
   // Execution pipeline across phases
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ir    <= 14'h0000;
         flush <= 1'b1;
         opnd  <= 8'h00;
         result <= 8'h00;
      end else begin
         case (q)
            MCX_Q1: opnd <= 8'h00;
            MCX_Q2: opnd <= file_rdata;
            MCX_Q3: result <= alu;
            MCX_Q4: begin
               ir <= instr_data;
               // Branch or skip discards the prefetched word
               flush <= is_branch || do_skip;
            end
            default: opnd <= opnd;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc         <= `MCX_RESET_VECTOR;
         file_addr  <= 7'h00;
         file_wdata <= 8'h00;
         file_we    <= 1'b0;
         acc        <= `MCX_ACC_RESET;
         zero_flag  <= 1'b0;
         watchdog_expiry_flag_n <= 1'b1;
         sleep_entry_flag_n     <= 1'b1;
         phase      <= 4'h1;
      end else begin
         phase     <= next_q;
         file_we   <= (q == MCX_Q3) && wr_reg;
         file_addr <= f_field;
         if (q == MCX_Q3) file_wdata <= alu;
         if (q == MCX_Q4) begin
            if (wr_acc) acc <= result;
            if (upd_z) zero_flag <= (result == 8'h00);
            if (do_wdt) begin
               watchdog_expiry_flag_n <= 1'b1;
               sleep_entry_flag_n     <= 1'b1;
            end
            pc <= is_branch ? br_tgt : pc + 13'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Return stack and watchdog
   // ------------------------------------------------------------
   mcx_stack_if stk ();
   assign stk.push      = (q == MCX_Q4) && live && (kind == MCX_K_CALL);
   // ir was fetched at pc - 1, so pc holds the return address here
   assign stk.push_data = pc;

   mcx_stack_mem u_stack (
      .clk   (mclk),
      .rst_n (rst_n),
      .stk   (stk)
   );
   assign stack_head = stk.stack_head;

   wire       wdt_clear = (q == MCX_Q4) && do_wdt;
   logic [7:0] pre_cnt_unused;
   mcx_wdt_clr u_wdt (
      .clk       (mclk),
      .rst_n     (rst_n),
      .clear     (wdt_clear),
      .tick      (wdt_tick),
      .ratio     (wdt_ratio),
      .count     (watchdog_counter),
      .pre_count (pre_cnt_unused)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_phase_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
      q == MCX_Q1 |=> q == MCX_Q2 ##1 q == MCX_Q3 ##1 q == MCX_Q4)
      else $error("phase order broken");
   a_call_target: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && live && kind == MCX_K_CALL) |=>
      pc == $past(br_tgt) && stack_head == $past(pc))
      else $error("call target or push wrong");
   a_branch_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && is_branch) |=> flush [*4])
      else $error("branch second cycle not idle");
   a_goto_nopush: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && live && kind == MCX_K_GOTO) |-> !stk.push)
      else $error("goto pushed");
   a_zero_follow: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && upd_z) |=>
      zero_flag == ($past(result) == 8'h00))
      else $error("zero flag mismatch");
   a_clr_reg: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q3 && live && kind == MCX_K_CLEAR_REGISTER_OP) |=>
      file_we && file_wdata == 8'h00 ##1 zero_flag)
      else $error("clear register failed");
   a_clr_acc: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && live && kind == MCX_K_CLEAR_ACCUMULATOR_OP) |=>
      acc == 8'h00 && zero_flag)
      else $error("clear accumulator failed");
   a_wdt_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      wdt_clear |=> watchdog_counter == 8'h00 &&
      watchdog_expiry_flag_n && sleep_entry_flag_n)
      else $error("watchdog clear failed");
   a_skip_flush: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && do_skip) |=> flush)
      else $error("skip did not discard");
   a_skip_noflag: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q4 && live && (kind == MCX_K_DECSZ ||
      kind == MCX_K_INCSZ)) |=> $stable(zero_flag))
      else $error("skip op changed flag");
   a_or_lit: assert property (@(posedge mclk) disable iff (!rst_n)
      (q == MCX_Q3 && live && kind == MCX_K_IORL) |=>
      ##1 acc == ($past(acc, 2) | $past(lit8, 2)))
      else $error("or literal wrong");

   c_call:  cover property (@(posedge mclk) stk.push);
   c_skip:  cover property (@(posedge mclk) q == MCX_Q4 && do_skip);
   c_wdt:   cover property (@(posedge mclk) wdt_clear);
   c_wrap:  cover property (@(posedge mclk)
      q == MCX_Q4 && live && kind == MCX_K_INCSZ && result == 8'h00);
endmodule // mcx_core

/* File: verif/mcx_mem_model.sv */
// Program memory and data register file seen by the execute block
`timescale 1ns/1ps
module mcx_mem_model (
   input  wire logic        mclk,
   input  wire logic [12:0] pc,
   output logic      [13:0] instr_data,
   input  wire logic [6:0]  file_addr,
   output logic      [7:0]  file_rdata,
   input  wire logic [7:0]  file_wdata,
   input  wire logic        file_we
);
   logic [13:0] rom  [0:8191];
   logic [7:0]  regs [0:127];

   // -------------------------------------------------
   // Word at the program counter, register at the address
   // -------------------------------------------------
   assign instr_data = rom[pc];
   assign file_rdata = regs[file_addr];

   always @(posedge mclk) begin
      if (file_we === 1'b1) begin
         regs[file_addr] <= file_wdata;
      end
   end
endmodule // mcx_mem_model

/* File: verif/midrange_core_instr_exec_test.sv */
// Self-checking testbench for the instruction execute block
`timescale 1ns/1ps
`include "mcx_defines.svh"
module midrange_core_instr_exec_test;
   logic        mclk, nrst, file_we, zero_flag, wdt_tick;
   logic        watchdog_expiry_flag_n, sleep_entry_flag_n;
   logic [13:0] instr_data;
   logic [12:0] pc, stack_head;
   logic [6:0]  file_addr;
   logic [7:0]  file_rdata, file_wdata, acc, watchdog_counter;
   logic [4:0]  pc_upper_holding_latch;
   logic [2:0]  wdt_ratio;
   logic [3:0]  phase;
   logic [14:0] exp_q [$];
   int          n_errors = 0;
   int          checks = 0;
   int          seed = 34;

   mcx_core mcx_core_i (.mclk(mclk), .nrst(nrst), .instr_data(instr_data),
      .pc(pc), .file_addr(file_addr), .file_rdata(file_rdata),
      .file_wdata(file_wdata), .file_we(file_we), .acc(acc),
      .zero_flag(zero_flag),
      .watchdog_expiry_flag_n(watchdog_expiry_flag_n),
      .sleep_entry_flag_n(sleep_entry_flag_n),
      .pc_upper_holding_latch(pc_upper_holding_latch),
      .wdt_ratio(wdt_ratio), .wdt_tick(wdt_tick),
      .watchdog_counter(watchdog_counter), .stack_head(stack_head),
      .phase(phase));

   mcx_mem_model mcx_mem_model_i (.mclk(mclk), .pc(pc),
      .instr_data(instr_data), .file_addr(file_addr),
      .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we));

   // -------------------------------------------------
   // Shared tasks
   // -------------------------------------------------
   task check(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task finish_test;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Holds the core in reset so the memories can be reloaded safely
   task rst_on;
      int i;
      @(posedge mclk);
      nrst <= 1'b0;
      wdt_tick <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 8192; i++) mcx_mem_model_i.rom[i] = 14'h0000;
      for (i = 0; i < 128; i++) mcx_mem_model_i.regs[i] = 8'h00;
   endtask

   task run(input logic [4:0] hl, input int clocks);
      pc_upper_holding_latch <= hl;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      repeat (clocks) @(posedge mclk);
   endtask

   function automatic logic [13:0] fop(logic [5:0] op, logic d,
                                       logic [6:0] f);
      return {op, d, f};
   endfunction

   // -------------------------------------------------
   // Result watcher: each register write meets the oldest note
   // -------------------------------------------------
   always @(posedge mclk) begin
      if (file_we === 1'b1) begin
         check("write phase", {12'h000, phase}, 16'h0008);
         if (exp_q.size() == 0)
            check("unexpected write", {1'b0, file_addr, file_wdata}, 16'hffff);
         else
            check("register write", {1'b0, file_addr, file_wdata}, {1'b0, exp_q.pop_front()});
      end
   end

   initial begin
      mclk = 1'b0;
      forever #(`MCX_CLK_PERIOD_NS / 2) mclk = ~mclk;
   end

   initial begin
      #(5000 * `MCX_CLK_PERIOD_NS);
      n_errors++;
      $display("[FAIL] run length expected done seen timeout");
      finish_test;
   end

   initial begin
      logic [7:0] r, k, n, a;
      nrst = 1'b0;
      pc_upper_holding_latch = 5'h00;
      wdt_ratio = 3'h0;
      wdt_tick = 1'b0;
      // Complement, increment, decrement, OR literal, goto
      r = $random(seed);
      k = $random(seed);
      n = ~r;
      a = (n + 8'h01) | k;
      rst_on;
      mcx_mem_model_i.regs[32] = r;
      mcx_mem_model_i.rom[0] = fop(`MCX_OP_INVERT_REGISTER_OP, 1'b1, 7'h20);
      mcx_mem_model_i.rom[1] = fop(`MCX_OP_INCREMENT_REGISTER_OP, 1'b0, 7'h20);
      mcx_mem_model_i.rom[2] = fop(`MCX_OP_DECREMENT_REGISTER_OP, 1'b1, 7'h20);
      mcx_mem_model_i.rom[3] = {`MCX_OP_OR_LITERAL_OP, k};
      mcx_mem_model_i.rom[4] = {`MCX_OP_GOTO, 11'h004};
      exp_q.push_back({7'h20, n});
      exp_q.push_back({7'h20, n - 8'h01});
      run({2'b00, 3'($random(seed))}, 160);
      check("acc or", {8'h00, acc}, {8'h00, a});
      check("zero or", {15'h0, zero_flag}, {15'h0, a == 8'h00});
      check("goto loop", {15'h0, pc === 13'h0004 || pc === 13'h0005}, 16'h0001);
      check("no push", {3'h0, stack_head}, 16'h0000);
      // Call into the upper page, clear accumulator
      rst_on;
      mcx_mem_model_i.regs[48] = 8'h5a;
      mcx_mem_model_i.rom[0] = {`MCX_OP_CALL, 11'h123};
      mcx_mem_model_i.rom[1] = {`MCX_OP_CLRREG, 7'h30};
      mcx_mem_model_i.rom[13'h1923] = {`MCX_OP_OR_LITERAL_OP, k | 8'h01};
      mcx_mem_model_i.rom[13'h1924] = {`MCX_OP_CLRACC, 7'($random(seed))};
      mcx_mem_model_i.rom[13'h1925] = {`MCX_OP_GOTO, 11'h125};
      run({2'b11, 3'($random(seed))}, 160);
      check("return address", {3'h0, stack_head}, 16'h0001);
      check("call page", {14'h0, pc[12:11]}, 16'h0003);
      check("acc cleared", {8'h00, acc}, 16'h0000);
      check("zero set", {15'h0, zero_flag}, 16'h0001);
      check("flushed slot", {8'h00, mcx_mem_model_i.regs[48]}, 16'h005a);
      // Skips on zero and on a set bit; flags left alone
      rst_on;
      mcx_mem_model_i.regs[33] = 8'h01;
      mcx_mem_model_i.regs[34] = 8'hff;
      mcx_mem_model_i.regs[35] = 8'h80;
      mcx_mem_model_i.regs[36] = 8'h02;
      mcx_mem_model_i.rom[0] = {`MCX_OP_OR_LITERAL_OP, 8'h01};
      mcx_mem_model_i.rom[1] = fop(`MCX_OP_DECREMENT_SKIP_ZERO_OP, 1'b1, 7'h21);
      mcx_mem_model_i.rom[2] = {`MCX_OP_CLRREG, 7'h25};
      mcx_mem_model_i.rom[3] = fop(`MCX_OP_INCREMENT_SKIP_ZERO_OP, 1'b1, 7'h22);
      mcx_mem_model_i.rom[4] = {`MCX_OP_CLRREG, 7'h26};
      mcx_mem_model_i.rom[5] = {`MCX_OP_BIT_TEST_SKIP_SET_OP, 3'h7, 7'h23};
      mcx_mem_model_i.rom[6] = {`MCX_OP_CLRREG, 7'h27};
      mcx_mem_model_i.rom[7] = fop(`MCX_OP_DECREMENT_SKIP_ZERO_OP, 1'b1, 7'h24);
      mcx_mem_model_i.rom[8] = fop(`MCX_OP_DECREMENT_SKIP_ZERO_OP, 1'b0, 7'h24);
      mcx_mem_model_i.rom[9] = {`MCX_OP_CLRREG, 7'h28};
      mcx_mem_model_i.rom[10] = {`MCX_OP_GOTO, 11'h00a};
      exp_q.push_back({7'h21, 8'h00});
      exp_q.push_back({7'h22, 8'h00});
      exp_q.push_back({7'h24, 8'h01});
      run(5'h00, 200);
      check("skip acc", {8'h00, acc}, 16'h0000);
      check("skip zero", {15'h0, zero_flag}, 16'h0000);
      check("writes done", 16'(exp_q.size()), 16'h0000);
      // Clear watchdog after counting
      rst_on;
      mcx_mem_model_i.rom[60] = `MCX_OP_CLEAR_WATCHDOG_OP;
      mcx_mem_model_i.rom[61] = {`MCX_OP_GOTO, 11'h03d};
      wdt_ratio <= {2'b00, 1'($random(seed))};
      run(5'h00, 2);
      wdt_tick <= 1'b1;
      repeat (120) @(posedge mclk);
      wdt_tick <= 1'b0;
      @(posedge mclk);
      check("watchdog counting", {15'h0, watchdog_counter !== 8'h00}, 16'h0001);
      repeat (200) @(posedge mclk);
      check("watchdog cleared", {8'h00, watchdog_counter}, 16'h0000);
      check("expiry flag", {15'h0, watchdog_expiry_flag_n}, 16'h0001);
      check("sleep flag", {15'h0, sleep_entry_flag_n}, 16'h0001);
      finish_test;
   end
endmodule // midrange_core_instr_exec_test
